//--- pru_pkg.sv
// constants and register layout of the paged address relocation unit
`default_nettype none
package pru_pkg;
  // bus geometry
  localparam int PRU_ADDR_W = 10;
  localparam int PRU_DATA_W = 32;
  localparam int PRU_PAIRS = 48;
  // byte offsets of the register windows
  localparam logic [9:0] PRU_BASE_OFS = 10'h000;
  localparam logic [9:0] PRU_DESC_OFS = 10'h100;
  localparam logic [9:0] PRU_CTRL_OFS = 10'h200;
  localparam logic [9:0] PRU_STAT_OFS = 10'h204;
  // descriptor field positions
  localparam int PRU_ACF_LSB = 0;
  localparam int PRU_DIR_BIT = 3;
  localparam int PRU_WFLAG_BIT = 6;
  localparam int PRU_AFLAG_BIT = 7;
  localparam int PRU_PLF_LSB = 8;
  // control field positions
  localparam int PRU_CTRL_EN_BIT = 0;
  localparam int PRU_CTRL_WIDE_BIT = 1;
  localparam int PRU_CTRL_SEPD_LSB = 4;
  // status field positions
  localparam int PRU_STAT_PEND_BIT = 0;
  localparam int PRU_STAT_ABORT_BIT = 1;
  localparam int PRU_STAT_LEN_BIT = 2;
  // access codes
  localparam logic [2:0] PRU_ACF_NONRES = 3'h0;
  localparam logic [2:0] PRU_ACF_RO_TRAP = 3'h1;
  localparam logic [2:0] PRU_ACF_RO = 3'h2;
  localparam logic [2:0] PRU_ACF_RSV3 = 3'h3;
  localparam logic [2:0] PRU_ACF_RW_TRAP = 3'h4;
  localparam logic [2:0] PRU_ACF_RW_WTRAP = 3'h5;
  localparam logic [2:0] PRU_ACF_RW = 3'h6;
  localparam logic [2:0] PRU_ACF_RSV7 = 3'h7;
  // processor mode codes
  localparam logic [1:0] PRU_MODE_KERNEL = 2'h0;
  localparam logic [1:0] PRU_MODE_SUPER = 2'h1;
  localparam logic [1:0] PRU_MODE_USER = 2'h3;
  // reset values and masks
  localparam logic [15:0] PRU_BASE_RST = 16'h0000;
  localparam logic [6:0] PRU_PLF_RST = 7'h00;
  localparam logic [2:0] PRU_ACF_RST = 3'h0;
  localparam logic [15:0] PRU_BASE12_MASK = 16'h0fff;
  localparam logic [21:0] PRU_PHYS18_MASK = 22'h03ffff;
endpackage : pru_pkg
`default_nettype wire

//--- pru_relocation_unit.sv
// paged address relocation unit with avalon register slave
`default_nettype none
module pru_relocation_unit (
  input wire logic sys_clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [pru_pkg::PRU_ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [pru_pkg::PRU_DATA_W-1:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [pru_pkg::PRU_DATA_W-1:0] avsReaddata,
  output logic avsWaitrequest,
  // processor reference port
  input wire logic refValid,
  input wire logic [15:0] refAddr,
  input wire logic refWrite,
  input wire logic refIsData,
  input wire logic [1:0] refMode,
  input wire logic instrDone,
  output logic refAck,
  output logic [21:0] refPhysAddr,
  output logic refAbort,
  output logic refLengthFault,
  output logic refTrapped,
  output logic trapTake
);
  import pru_pkg::*;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [15:0] baseMem [0:PRU_PAIRS-1];
  logic [6:0] plfMem [0:PRU_PAIRS-1];
  logic [2:0] acfMem [0:PRU_PAIRS-1];
  logic [PRU_PAIRS-1:0] dirMem;
  logic [PRU_PAIRS-1:0] wFlag;
  logic [PRU_PAIRS-1:0] aFlag;
  logic relocEnable;
  logic wide22;
  logic [2:0] sepData;
  logic trapPending;
  logic lastAbort;
  logic lastLenFault;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic busAccept;
  logic busWr;
  logic [5:0] swIdx;
  logic swBaseHit;
  logic swDescHit;
  logic swCtrlHit;
  logic swStatHit;
  logic swBaseWr;
  logic swDescWr;
  logic [PRU_PAIRS-1:0] swClear;
  logic [PRU_DATA_W-1:0] next_readdata;

  // a request is served at the edge where waitrequest is seen low
  assign busAccept = (avsRead || avsWrite) && !avsWaitrequest;
  assign busWr = avsWrite && busAccept;
  assign swIdx = avsAddress[7:2];
  assign swBaseHit = (avsAddress[9:8] == PRU_BASE_OFS[9:8]) && (swIdx < 6'(PRU_PAIRS));
  assign swDescHit = (avsAddress[9:8] == PRU_DESC_OFS[9:8]) && (swIdx < 6'(PRU_PAIRS));
  assign swCtrlHit = (avsAddress[9:2] == PRU_CTRL_OFS[9:2]);
  assign swStatHit = (avsAddress[9:2] == PRU_STAT_OFS[9:2]);
  assign swBaseWr = busWr && swBaseHit;
  assign swDescWr = busWr && swDescHit;

  always_comb begin
    swClear = '0;
    if (swBaseWr || swDescWr) begin
      swClear[swIdx] = 1'b1;
    end
  end

  always_comb begin
    next_readdata = '0;
    if (swBaseHit) begin
      next_readdata[15:0] = baseMem[swIdx];
    end else if (swDescHit) begin
      next_readdata[PRU_PLF_LSB +: 7] = plfMem[swIdx];
      next_readdata[PRU_AFLAG_BIT] = aFlag[swIdx];
      next_readdata[PRU_WFLAG_BIT] = wFlag[swIdx];
      next_readdata[PRU_DIR_BIT] = dirMem[swIdx];
      next_readdata[PRU_ACF_LSB +: 3] = acfMem[swIdx];
    end else if (swCtrlHit) begin
      next_readdata[PRU_CTRL_EN_BIT] = relocEnable;
      next_readdata[PRU_CTRL_WIDE_BIT] = wide22;
      next_readdata[PRU_CTRL_SEPD_LSB +: 3] = sepData;
    end else if (swStatHit) begin
      next_readdata[PRU_STAT_PEND_BIT] = trapPending;
      next_readdata[PRU_STAT_ABORT_BIT] = lastAbort;
      next_readdata[PRU_STAT_LEN_BIT] = lastLenFault;
    end
  end

  // fixed one wait state: waitrequest drops the cycle after a request
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avsWaitrequest <= 1'b1;
      avsReaddata <= '0;
    end else begin
      avsWaitrequest <= !((avsRead || avsWrite) && avsWaitrequest);
      if (avsRead && avsWaitrequest) begin
        avsReaddata <= next_readdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // software-written registers
  // ----------------------------------------------------------------
  // byte lanes: base and descriptor take lanes 0 and 1, control lane 0
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < PRU_PAIRS; i++) begin
        baseMem[i] <= PRU_BASE_RST;
        plfMem[i] <= PRU_PLF_RST;
        acfMem[i] <= PRU_ACF_RST;
      end
      dirMem <= '0;
    end else begin
      if (swBaseWr) begin
        if (avsByteenable[0]) baseMem[swIdx][7:0] <= avsWritedata[7:0];
        if (avsByteenable[1]) baseMem[swIdx][15:8] <= avsWritedata[15:8];
      end
      if (swDescWr) begin
        if (avsByteenable[0]) begin
          acfMem[swIdx] <= avsWritedata[PRU_ACF_LSB +: 3];
          dirMem[swIdx] <= avsWritedata[PRU_DIR_BIT];
        end
        if (avsByteenable[1]) plfMem[swIdx] <= avsWritedata[PRU_PLF_LSB +: 7];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      relocEnable <= 1'b0;
      wide22 <= 1'b0;
      sepData <= 3'h0;
    end else if (busWr && swCtrlHit && avsByteenable[0]) begin
      relocEnable <= avsWritedata[PRU_CTRL_EN_BIT];
      wide22 <= avsWritedata[PRU_CTRL_WIDE_BIT];
      sepData <= avsWritedata[PRU_CTRL_SEPD_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------
  // translation
  // ----------------------------------------------------------------
  logic [1:0] modeIdx;
  logic modeOk;
  logic useData;
  logic [2:0] pageSel;
  logic [6:0] blockIdx;
  logic [5:0] wordInBlock;
  logic [5:0] pairIdx;
  logic [2:0] acf;
  logic [6:0] page_length_field;
  logic [15:0] baseField;
  logic [15:0] blockSum;
  logic [21:0] relocAddr;
  logic lenFault;
  logic acfAbort;
  logic abortC;
  logic trapC;
  logic newTrap;
  logic doneWrite;

  always_comb begin
    modeOk = 1'b1;
    modeIdx = 2'h0;
    unique case (refMode)
      PRU_MODE_KERNEL: modeIdx = 2'h0;
      PRU_MODE_SUPER: modeIdx = 2'h1;
      PRU_MODE_USER: modeIdx = 2'h2;
      default: modeOk = 1'b0;
    endcase
  end

  // data references fall back to the instruction set unless enabled
  assign useData = refIsData && sepData[modeIdx];
  assign pageSel = refAddr[15:13];
  assign blockIdx = refAddr[12:6];
  assign wordInBlock = refAddr[5:0];
  assign pairIdx = {modeIdx, useData, pageSel};
  assign acf = acfMem[pairIdx];
  assign page_length_field = plfMem[pairIdx];
  assign baseField = wide22 ? baseMem[pairIdx] : (baseMem[pairIdx] & PRU_BASE12_MASK);
  // base counts 64-word blocks, so pages always start on a block boundary
  assign blockSum = baseField + {9'h000, blockIdx};
  assign relocAddr = wide22 ? {blockSum, wordInBlock}
                            : ({blockSum, wordInBlock} & PRU_PHYS18_MASK);
  assign lenFault = dirMem[pairIdx] ? (blockIdx < page_length_field) : (blockIdx > page_length_field);

  // refWrite covers stores and read-modify cycles alike
  always_comb begin
    acfAbort = 1'b0;
    unique case (acf)
      PRU_ACF_NONRES: acfAbort = 1'b1;
      PRU_ACF_RO_TRAP, PRU_ACF_RO: acfAbort = refWrite;
      PRU_ACF_RSV3, PRU_ACF_RSV7: acfAbort = 1'b1;
      PRU_ACF_RW_TRAP, PRU_ACF_RW_WTRAP, PRU_ACF_RW: acfAbort = 1'b0;
    endcase
  end

  assign abortC = relocEnable && (!modeOk || acfAbort || lenFault);
  assign trapC = relocEnable && !abortC &&
                 (((acf == PRU_ACF_RO_TRAP) && !refWrite) ||
                  (acf == PRU_ACF_RW_TRAP) ||
                  ((acf == PRU_ACF_RW_WTRAP) && refWrite));
  assign newTrap = refValid && trapC;
  // an aborted reference never completes, so marks nothing
  assign doneWrite = refValid && relocEnable && refWrite && !abortC;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      refAck <= 1'b0;
      refPhysAddr <= '0;
      refAbort <= 1'b0;
      refLengthFault <= 1'b0;
      refTrapped <= 1'b0;
    end else begin
      refAck <= refValid;
      refAbort <= refValid && abortC;
      refLengthFault <= refValid && relocEnable && modeOk && lenFault;
      refTrapped <= newTrap;
      if (refValid) begin
        refPhysAddr <= relocEnable ? relocAddr : {6'h00, refAddr};
      end
    end
  end

  // ----------------------------------------------------------------
  // page flags: hardware set wins over software clear
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wFlag <= '0;
      aFlag <= '0;
    end else begin
      for (int i = 0; i < PRU_PAIRS; i++) begin
        wFlag[i] <= (wFlag[i] && !swClear[i]) || (doneWrite && (pairIdx == 6'(i)));
        aFlag[i] <= (aFlag[i] && !swClear[i]) || (newTrap && (pairIdx == 6'(i)));
      end
    end
  end

  // ----------------------------------------------------------------
  // deferred trap
  // ----------------------------------------------------------------
  // a trap raised in the finishing cycle belongs to that instruction
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trapPending <= 1'b0;
      trapTake <= 1'b0;
    end else begin
      trapTake <= instrDone && (trapPending || newTrap);
      trapPending <= !instrDone && (trapPending || newTrap);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lastAbort <= 1'b0;
      lastLenFault <= 1'b0;
    end else if (refValid) begin
      lastAbort <= abortC;
      lastLenFault <= relocEnable && modeOk && lenFault;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  nonres_abort_a: assert property (
    refValid && relocEnable && modeOk && acf == PRU_ACF_NONRES |=> refAck && refAbort && !refTrapped)
    else $error("non-resident page not aborted");
  ro_write_a: assert property (
    refValid && relocEnable && refWrite && (acf == PRU_ACF_RO || acf == PRU_ACF_RO_TRAP) |=> refAbort)
    else $error("write to read-only page not aborted");
  rsv_abort_a: assert property (
    refValid && relocEnable && (acf == PRU_ACF_RSV3 || acf == PRU_ACF_RSV7) |=> refAbort)
    else $error("reserved code not aborted");
  rw_trap_a: assert property (
    refValid && relocEnable && modeOk && !lenFault && acf == PRU_ACF_RW_TRAP |=> refTrapped && !refAbort)
    else $error("trap missing under code 100");
  wtrap_read_a: assert property (
    refValid && relocEnable && !refWrite && acf == PRU_ACF_RW_WTRAP |=> !refTrapped)
    else $error("read trapped under code 101");
  plain_rw_a: assert property (
    refValid && relocEnable && modeOk && !lenFault && acf == PRU_ACF_RW |=> !refTrapped && !refAbort)
    else $error("action taken under code 110");
  written_set_a: assert property (
    doneWrite |=> wFlag[$past(pairIdx)])
    else $error("written flag not set");
  attn_clear_a: assert property (
    swDescWr && !newTrap |=> !aFlag[$past(swIdx)])
    else $error("attention flag not cleared");
  pass_through_a: assert property (
    refValid && !relocEnable |=> refPhysAddr == {6'h00, $past(refAddr)} && !refAbort)
    else $error("address not passed through");
  up_length_a: assert property (
    refValid && relocEnable && !dirMem[pairIdx] && blockIdx > page_length_field |=> refAbort)
    else $error("upward length fault missed");
  down_length_a: assert property (
    refValid && relocEnable && dirMem[pairIdx] && blockIdx < page_length_field |=> refAbort)
    else $error("downward length fault missed");
  trap_defer_a: assert property (
    trapTake |-> $past(instrDone) && !trapPending)
    else $error("trap taken mid-instruction");
  ro_trap_read_a: assert property (
    refValid && relocEnable && modeOk && !lenFault && !refWrite && acf == PRU_ACF_RO_TRAP |=> refTrapped && !refAbort)
    else $error("read under code 001 not trapped");
  wtrap_write_a: assert property (
    refValid && relocEnable && modeOk && !lenFault && refWrite && acf == PRU_ACF_RW_WTRAP |=> refTrapped && !refAbort)
    else $error("write under code 101 not trapped");
  written_clear_a: assert property (
    (swBaseWr || swDescWr) && !doneWrite |=> !wFlag[$past(swIdx)])
    else $error("written flag not cleared");
  attn_set_a: assert property (
    newTrap |=> aFlag[$past(pairIdx)])
    else $error("attention flag not set");
  bad_mode_a: assert property (
    refValid && relocEnable && refMode == 2'h2 |=> refAbort)
    else $error("illegal mode not aborted");
  abort_no_trap_a: assert property (
    refAck && refAbort |-> !refTrapped)
    else $error("aborted reference also trapped");
  abort_no_mark_a: assert property (
    refValid && abortC && !swBaseWr && !swDescWr |=> wFlag == $past(wFlag))
    else $error("aborted reference marked page written");
  block_offset_a: assert property (
    refValid |=> refPhysAddr[5:0] == $past(refAddr[5:0]))
    else $error("offset in block not kept");
  pend_hold_a: assert property (
    trapPending && !instrDone |=> trapPending && !trapTake)
    else $error("pending trap lost or taken early");
endmodule : pru_relocation_unit
`default_nettype wire

//--- pru_core_model.sv
// processor core model issuing virtual references to the relocation unit
`default_nettype none
module pru_core_model (
  input wire logic sys_clk,
  output logic refValid,
  output logic [15:0] refAddr,
  output logic refWrite,
  output logic refIsData,
  output logic [1:0] refMode,
  output logic instrDone,
  input wire logic refAck,
  input wire logic [21:0] refPhysAddr,
  input wire logic refAbort,
  input wire logic refLengthFault,
  input wire logic refTrapped,
  input wire logic trapTake
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // reference and completion tasks
  // ----------------------------------------
  logic [25:0] got;
  logic took;
  initial begin
    refValid = 1'b0;
    refAddr = 16'h0000;
    refWrite = 1'b0;
    refIsData = 1'b0;
    refMode = 2'h0;
    instrDone = 1'b0;
  end
  // idle lines carry the inverse of the last reference, so a stale copy never looks valid
  task automatic issue(input logic [15:0] va, input logic wr, input logic dat, input logic [1:0] md);
    @(posedge sys_clk);
    refValid <= 1'b1;
    refAddr <= va;
    refWrite <= wr;
    refIsData <= dat;
    refMode <= md;
    @(posedge sys_clk);
    refValid <= 1'b0;
    refAddr <= ~va;
    refWrite <= ~wr;
    refIsData <= ~dat;
    refMode <= ~md;
    @(posedge sys_clk);
    got = {refAck, refAbort, refLengthFault, refTrapped, refPhysAddr};
  endtask : issue
  // instruction boundary: only after it may a pending trap surface
  task automatic endInstr();
    @(posedge sys_clk);
    instrDone <= 1'b1;
    @(posedge sys_clk);
    instrDone <= 1'b0;
    @(posedge sys_clk);
    took = trapTake;
  endtask : endInstr
endmodule : pru_core_model
`default_nettype wire

//--- paged_address_relocation_unit_bench.sv
// self-checking bench of the paged address relocation unit
`default_nettype none
module paged_address_relocation_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import pru_pkg::*;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic sys_clk, sys_rst, avsRead, avsWrite, avsWaitrequest;
  logic [PRU_ADDR_W-1:0] avsAddress;
  logic [PRU_DATA_W-1:0] avsWritedata, avsReaddata;
  logic [3:0] avsByteenable;
  logic refValid, refWrite, refIsData, instrDone, refAck, refAbort, refLengthFault, refTrapped, trapTake;
  logic [15:0] refAddr;
  logic [1:0] refMode;
  logic [21:0] refPhysAddr;
  logic [1:0] md [3] = '{PRU_MODE_KERNEL, PRU_MODE_SUPER, PRU_MODE_USER};
  int fails, checked, cycles;
  logic ab, tr;
  pru_relocation_unit dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .refValid(refValid), .refAddr(refAddr), .refWrite(refWrite),
    .refIsData(refIsData), .refMode(refMode), .instrDone(instrDone), .refAck(refAck), .refPhysAddr(refPhysAddr),
    .refAbort(refAbort), .refLengthFault(refLengthFault), .refTrapped(refTrapped), .trapTake(trapTake));
  pru_core_model core_u (.sys_clk(sys_clk), .refValid(refValid), .refAddr(refAddr), .refWrite(refWrite),
    .refIsData(refIsData), .refMode(refMode), .instrDone(instrDone), .refAck(refAck), .refPhysAddr(refPhysAddr),
    .refAbort(refAbort), .refLengthFault(refLengthFault), .refTrapped(refTrapped), .trapTake(trapTake));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // request held until waitrequest is seen low; the global timeout cuts a hang
  task automatic busCycle(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    avsAddress <= a;
    avsRead <= ~w;
    avsWrite <= w;
    avsWritedata <= d;
    do @(posedge sys_clk); while (avsWaitrequest !== 1'b0);
    q = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask : busCycle
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    busCycle(1'b1, a, d, q);
  endtask : wr
  task automatic rdChk(input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] q;
    busCycle(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rdChk
  // physical address is only meaningful when the reference was not aborted
  task automatic refChk(input logic [15:0] va, input logic w, input logic d, input logic [1:0] m,
                        input logic a, input logic lf, input logic t, input logic [21:0] pa);
    logic [25:0] s;
    core_u.issue(va, w, d, m);
    s = core_u.got;
    if (a) s[21:0] = 22'h0;
    check({6'h0, s}, {6'h0, 1'b1, a, lf, t, a ? 22'h0 : pa});
  endtask : refChk
  function automatic logic [21:0] physOf(input logic [15:0] b, input logic [15:0] va, input logic wide);
    logic [21:0] blk;
    blk = {6'h0, wide ? b : (b & 16'h0fff)} + {15'h0, va[12:6]};
    return wide ? {blk[15:0], va[5:0]} : {4'h0, blk[11:0], va[5:0]};
  endfunction : physOf
  function automatic logic [15:0] baseOf(input int p);
    return 16'(32'hf000 + 17 * p);
  endfunction : baseOf
  // ----------------------------------------
  // clock, timeout and test sequence
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    cycles = 0;
    forever begin
      @(posedge sys_clk);
      cycles++;
      if (cycles >= 20000) begin
        fails++;
        stop_test();
      end
    end
  end
  initial begin
    sys_rst = 1'b1;
    avsAddress = '0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWritedata = '0;
    avsByteenable = 4'hf;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rdChk(PRU_CTRL_OFS, 32'h0);
    rdChk(PRU_DESC_OFS, 32'h0);
    rdChk(10'h3fc, 32'h0);
    refChk(16'hbeef, 1'b1, 1'b1, PRU_MODE_USER, 1'b0, 1'b0, 1'b0, 22'h00beef);
    wr(PRU_CTRL_OFS, 32'h3);
    for (int c = 0; c < 8; c++) begin
      for (int w = 0; w < 2; w++) begin
        ab = c == 0 || c == 3 || c == 7 || ((c == 1 || c == 2) && w == 1);
        tr = !ab && ((c == 1 && w == 0) || c == 4 || (c == 5 && w == 1));
        wr(PRU_BASE_OFS + 10'h4, 32'h100);
        wr(PRU_DESC_OFS + 10'h4, 32'h7f00 | c);
        refChk(16'h2083, w[0], 1'b0, 2'h0, ab, 1'b0, tr, 22'h4083);
        check({31'h0, trapTake}, 32'h0);
        rdChk(PRU_STAT_OFS, {30'h0, ab, tr});
        rdChk(PRU_DESC_OFS + 10'h4, 32'h7f00 | c | {!ab && w == 1, 6'h0} | {tr, 7'h0});
        core_u.endInstr();
        check({31'h0, core_u.took}, {31'h0, tr});
      end
    end
    wr(PRU_DESC_OFS + 10'h4, 32'h7f04);
    refChk(16'h2083, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b1, 22'h4083);
    rdChk(PRU_DESC_OFS + 10'h4, 32'h7fc4);
    wr(PRU_BASE_OFS + 10'h4, 32'h100);
    rdChk(PRU_DESC_OFS + 10'h4, 32'h7f04);
    refChk(16'h2083, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b1, 22'h4083);
    wr(PRU_DESC_OFS + 10'h4, 32'h7f04);
    rdChk(PRU_DESC_OFS + 10'h4, 32'h7f04);
    core_u.endInstr();
    check({31'h0, core_u.took}, 32'h1);
    wr(PRU_DESC_OFS + 10'h4, 32'h0506);
    refChk(16'h2143, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 22'h4143);
    refChk(16'h2183, 1'b0, 1'b0, 2'h0, 1'b1, 1'b1, 1'b0, 22'h0);
    rdChk(PRU_STAT_OFS, 32'h6);
    wr(PRU_DESC_OFS + 10'h4, 32'h050e);
    refChk(16'h2103, 1'b1, 1'b0, 2'h0, 1'b1, 1'b1, 1'b0, 22'h0);
    refChk(16'h2143, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 22'h4143);
    wr(PRU_CTRL_OFS, 32'h73);
    for (int m = 0; m < 3; m++) begin
      for (int s = 0; s < 2; s++) begin
        wr(PRU_BASE_OFS + 10'(4 * ((m * 2 + s) * 8 + 7)), {16'h0, baseOf((m * 2 + s) * 8 + 7)});
        wr(PRU_DESC_OFS + 10'(4 * ((m * 2 + s) * 8 + 7)), 32'h7f06);
      end
    end
    for (int m = 0; m < 3; m++) begin
      for (int s = 0; s < 2; s++) begin
        refChk(16'hffff, 1'b0, s[0], md[m], 1'b0, 1'b0, 1'b0, physOf(baseOf((m * 2 + s) * 8 + 7), 16'hffff, 1'b1));
      end
    end
    // without separate data space every data reference falls back to the instruction set
    wr(PRU_CTRL_OFS, 32'h01);
    for (int m = 0; m < 3; m++) begin
      for (int s = 0; s < 2; s++) begin
        refChk(16'hffff, 1'b0, s[0], md[m], 1'b0, 1'b0, 1'b0, physOf(baseOf(m * 16 + 7), 16'hffff, 1'b0));
      end
    end
    refChk(16'hffff, 1'b0, 1'b0, 2'h2, 1'b1, 1'b0, 1'b0, 22'h0);
    stop_test();
  end
endmodule : paged_address_relocation_unit_bench
`default_nettype wire
